// ===== dlcs_consts.svh
`ifndef DLCS_CONSTS_SVH
`define DLCS_CONSTS_SVH

`define DLCS_ADDR_W 8
`define DLCS_DATA_W 16

`define DLCS_ADDR_RET_COUNT 8'hc2
`define DLCS_ADDR_ACK_STATUS 8'hc3
`define DLCS_ADDR_LINE_CTRL 8'hc4

`define DLCS_LC_TURN_AFTER_WRITE 0
`define DLCS_LC_REPEAT_TURN 1
`define DLCS_LC_FORCED_CONTENTION 2
`define DLCS_LC_REG_TURN 3
`define DLCS_LC_RESET_TRIGGER 4
`define DLCS_LC_CONTENTION_DISREGARD 5
`define DLCS_LC_W 6

`define DLCS_RET_COUNT_RST 16'h0000
`define DLCS_ACK_STATUS_RST 16'h0000
`define DLCS_LINE_CTRL_RST 6'h00
`define DLCS_UNMAPPED_READ 16'h0000

`endif

// ===== dlcs_pkg.sv
`include "dlcs_consts.svh"

package dlcs_pkg;

	typedef struct packed {
		logic respValid;
		logic respIsAckErr;
		logic respIsRead;
		logic [`DLCS_DATA_W-1:0] respWord;
		logic phyContention;
		logic vertActive;
		logic videoMode;
		logic linkIdle;
		logic btaReturned;
		logic writePktDone;
		logic rstTrigDone;
		logic txRequest;
		logic hsSelect;
	} dlcs_link_in_t;

	typedef struct packed {
		logic txHalt;
		logic rstTrigReq;
		logic btaReq;
		logic lp11Force;
		logic lpHold;
		logic hsMode;
	} dlcs_link_out_t;

	typedef enum logic [1:0] {
		DLCS_BTA_IDLE = 2'b00,
		DLCS_BTA_REG = 2'b01,
		DLCS_BTA_WRITE = 2'b10,
		DLCS_BTA_REPEAT = 2'b11
	} dlcs_bta_t;

	typedef struct packed {
		logic contentionDisregard;
		logic resetTriggerRequest;
		logic registerTurnaroundRequest;
		logic forcedContention;
		logic repeatTurnaroundForTearing;
		logic turnaroundAfterWrite;
	} dlcs_line_ctrl_t;

endpackage

// ===== dlcs_link_sampler.sv
`timescale 1ns/10ps

module dlcs_link_sampler
	import dlcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic linkClk,
	input wire dlcs_link_in_t pinsIn,
	output dlcs_link_in_t held,
	output logic linkEdge
);

	typedef struct packed {
		logic clkMeta;
		logic clkSync;
		logic clkPrev;
		dlcs_link_in_t pinsMeta;
		dlcs_link_in_t pinsSync;
		dlcs_link_in_t held;
		logic edgeSeen;
	} dlcs_sampler_state_t;

	dlcs_sampler_state_t s_q;
	dlcs_sampler_state_t s_d;

	// meta stages feed only the second stage
	always_comb begin
		s_d = s_q;
		s_d.clkMeta = linkClk;
		s_d.clkSync = s_q.clkMeta;
		s_d.clkPrev = s_q.clkSync;
		s_d.pinsMeta = pinsIn;
		s_d.pinsSync = s_q.pinsMeta;
		s_d.edgeSeen = s_q.clkSync & ~s_q.clkPrev;
		// link pins settle long before its rising edge, capture at the edge
		if (s_q.clkSync & ~s_q.clkPrev) begin
			s_d.held = s_q.pinsSync;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign held = s_q.held;
	assign linkEdge = s_q.edgeSeen;

endmodule

// ===== dlcs_link_control_status.sv
// What this block does
// - Return count register at 0xC2 holds byte count of latest read response.
// - Return count and acknowledge status ignore software writes.
// - Acknowledge status at 0xC3 loads error report on ack-with-error packet.
// - Any other response clears acknowledge status to zero.
// - Acknowledge status bits keep the protocol's error report bit meanings.
// - Acting on contention, transmission stops after contention is reported.
// - Disregarding contention, transmission carries on with pending packets.
// - Writing 1 to line control bit 4 sends a reset trigger message.
// - Reset trigger during vertical active video waits for vertical blanking.
// - Reset trigger bit clears itself once the message is sent.
// - In video mode the register turnaround waits for vertical blanking.
// - Line control bit 2 drives data lane LP11 to force contention.
// - Forced-contention bit returns to 0 when contention is no longer detected.
// - Line control bit 1 at 0: no extra turnaround after a turnaround.
// - Line control bit 1 at 1: repeat turnaround to fetch tearing response.
// - Line control bit 0 requests a turnaround after each write packet.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "dlcs_consts.svh"

module dlcs_link_control_status
	import dlcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [`DLCS_ADDR_W-1:0] regAddr,
	input wire logic [`DLCS_DATA_W-1:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [`DLCS_DATA_W-1:0] regRdData,
	input wire logic linkClk,
	input wire dlcs_link_in_t linkIn,
	output dlcs_link_out_t linkOut
);

	typedef struct packed {
		logic [`DLCS_DATA_W-1:0] rdData;
		logic [`DLCS_DATA_W-1:0] retCount;
		logic [`DLCS_DATA_W-1:0] ackStatus;
		dlcs_line_ctrl_t lineCtrl;
		dlcs_bta_t btaState;
		logic btaReq;
		logic rstTrigReq;
		logic haltLatch;
		logic forceSeen;
		logic lpHold;
		logic hsMode;
	} dlcs_state_t;

	dlcs_state_t s_q;
	dlcs_state_t s_d;

	dlcs_link_in_t lnk;
	logic lnkEdge;

	dlcs_link_sampler u_sampler (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.linkClk(linkClk),
		.pinsIn(linkIn),
		.held(lnk),
		.linkEdge(lnkEdge)
	);

	// one-cycle events valid at the sampled link edge only, then the video-active level and the line control write strobe
	logic respEv;
	logic btaRetEv;
	logic writeDoneEv;
	logic rstDoneEv;
	logic txReqEv;
	logic videoActive;
	logic lineCtrlWr;

	assign respEv = lnkEdge & lnk.respValid;
	assign btaRetEv = lnkEdge & lnk.btaReturned;
	assign writeDoneEv = lnkEdge & lnk.writePktDone;
	assign rstDoneEv = lnkEdge & lnk.rstTrigDone;
	assign txReqEv = lnkEdge & lnk.txRequest;
	assign videoActive = lnk.videoMode & lnk.vertActive;
	assign lineCtrlWr = regWrStrobe & (regAddr == `DLCS_ADDR_LINE_CTRL);

	always_comb begin
		s_d = s_q;

		// response status; software never writes these two
		if (respEv) begin
			if (lnk.respIsAckErr) begin
				// bits passed through unchanged, protocol bit meanings kept
				s_d.ackStatus = lnk.respWord;
			end else begin
				s_d.ackStatus = `DLCS_ACK_STATUS_RST;
			end
			if (lnk.respIsRead) begin
				s_d.retCount = lnk.respWord;
			end
		end

		// contention handling
		if (lnkEdge & lnk.phyContention & ~s_q.lineCtrl.contentionDisregard) begin
			s_d.haltLatch = 1'b1;
		end else if (s_q.lineCtrl.contentionDisregard) begin
			s_d.haltLatch = 1'b0;
		end else if (lineCtrlWr) begin
			// software acknowledges a halt by rewriting line control
			s_d.haltLatch = 1'b0;
		end

		// forced contention ends once the phy stops reporting it
		if (s_q.lineCtrl.forcedContention & lnkEdge) begin
			if (lnk.phyContention) begin
				s_d.forceSeen = 1'b1;
			end else if (s_q.forceSeen) begin
				s_d.forceSeen = 1'b0;
				s_d.lineCtrl.forcedContention = 1'b0;
			end
		end
		if (~s_q.lineCtrl.forcedContention) begin
			s_d.forceSeen = 1'b0;
		end

		// reset trigger message
		if (s_q.rstTrigReq) begin
			if (rstDoneEv) begin
				s_d.rstTrigReq = 1'b0;
				s_d.lineCtrl.resetTriggerRequest = 1'b0;
			end
		end else if (s_q.lineCtrl.resetTriggerRequest & ~videoActive) begin
			s_d.rstTrigReq = 1'b1;
		end

		// low-power hold after a register turnaround
		if (s_q.lpHold & txReqEv) begin
			s_d.lpHold = 1'b0;
			s_d.hsMode = lnk.hsSelect;
		end

		// turnaround sequencing
		unique case (s_q.btaState)
			DLCS_BTA_IDLE: begin
				if (s_q.lineCtrl.registerTurnaroundRequest & lnk.linkIdle
						& ~s_q.rstTrigReq & ~(lnk.videoMode & lnk.vertActive)) begin
					// video mode waits for blanking
					s_d.btaState = DLCS_BTA_REG;
					s_d.btaReq = 1'b1;
					s_d.lineCtrl.registerTurnaroundRequest = 1'b0;
				end else if (writeDoneEv & s_q.lineCtrl.turnaroundAfterWrite) begin
					s_d.btaState = DLCS_BTA_WRITE;
					s_d.btaReq = 1'b1;
				end
			end
			DLCS_BTA_REG, DLCS_BTA_WRITE: begin
				if (btaRetEv) begin
					s_d.btaReq = 1'b0;
					if (s_q.btaState == DLCS_BTA_REG) begin
						s_d.lpHold = 1'b1;
					end
					if (s_q.lineCtrl.repeatTurnaroundForTearing) begin
						s_d.btaState = DLCS_BTA_REPEAT;
					end else begin
						s_d.btaState = DLCS_BTA_IDLE;
					end
				end
			end
			DLCS_BTA_REPEAT: begin
				// request drops for one link edge so the second one is seen
				if (~s_q.btaReq) begin
					if (lnkEdge) begin
						s_d.btaReq = 1'b1;
					end
				end else if (btaRetEv) begin
					s_d.btaReq = 1'b0;
					s_d.btaState = DLCS_BTA_IDLE;
				end
			end
		endcase

		// software write last, so a set written now beats a hardware clear
		if (lineCtrlWr) begin
			s_d.lineCtrl = regWrData[`DLCS_LC_W-1:0];
		end

		// read data stands only in the cycle after the strobe
		s_d.rdData = `DLCS_UNMAPPED_READ;
		if (regRdStrobe) begin
			unique case (regAddr)
				`DLCS_ADDR_RET_COUNT: s_d.rdData = s_q.retCount;
				`DLCS_ADDR_ACK_STATUS: s_d.rdData = s_q.ackStatus;
				`DLCS_ADDR_LINE_CTRL: begin
					s_d.rdData = {{(`DLCS_DATA_W-`DLCS_LC_W){1'b0}}, s_q.lineCtrl};
				end
				default: s_d.rdData = `DLCS_UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q.rdData <= `DLCS_UNMAPPED_READ;
			s_q.retCount <= `DLCS_RET_COUNT_RST;
			s_q.ackStatus <= `DLCS_ACK_STATUS_RST;
			s_q.lineCtrl <= `DLCS_LINE_CTRL_RST;
			s_q.btaState <= DLCS_BTA_IDLE;
			s_q.btaReq <= 1'b0;
			s_q.rstTrigReq <= 1'b0;
			s_q.haltLatch <= 1'b0;
			s_q.forceSeen <= 1'b0;
			s_q.lpHold <= 1'b0;
			s_q.hsMode <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData = s_q.rdData;
	assign linkOut.txHalt = s_q.haltLatch & ~s_q.lineCtrl.contentionDisregard;
	assign linkOut.rstTrigReq = s_q.rstTrigReq;
	assign linkOut.btaReq = s_q.btaReq;
	assign linkOut.lp11Force = s_q.lineCtrl.forcedContention;
	assign linkOut.lpHold = s_q.lpHold;
	assign linkOut.hsMode = s_q.hsMode;

endmodule

// ===== dlcs_link_control_status_sva.sv
`timescale 1ns/10ps
module dlcs_link_control_status_sva
	import dlcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	input wire logic [15:0] regRdData,
	input wire dlcs_link_in_t linkIn,
	input wire dlcs_link_out_t linkOut
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire logic lcWr = regWrStrobe && regAddr == 8'hc4;
	a_rd_data_idle: assert property (!$past(regRdStrobe) |-> regRdData == 16'h0000)
		else $error("read data not idle");
	a_rsv_read_zero: assert property (regRdStrobe && regAddr == 8'hc4 |=> regRdData[15:6] == 10'h000)
		else $error("reserved bits set");
	a_lp11_force_set: assert property (lcWr && regWrData[2] |=> ##[0:1] linkOut.lp11Force)
		else $error("lp11 not forced");
	a_bta_until_back: assert property ($fell(linkOut.btaReq) |-> linkIn.btaReturned)
		else $error("turnaround dropped early");
	a_rt_until_done: assert property ($fell(linkOut.rstTrigReq) |-> linkIn.rstTrigDone)
		else $error("reset trigger dropped early");
	a_force_clear_cause: assert property ($fell(linkOut.lp11Force) |-> !linkIn.phyContention || $past(lcWr) || $past(lcWr, 2))
		else $error("lp11 cleared under contention");
	a_ignore_no_halt: assert property (lcWr && regWrData[5] |-> ##3 !linkOut.txHalt [*4])
		else $error("halt while disregarding");
	a_lp_end_request: assert property ($fell(linkOut.lpHold) |-> linkIn.txRequest ##[0:1] linkOut.hsMode == linkIn.hsSelect)
		else $error("low power left wrongly");
	cover property ($rose(linkOut.btaReq));
	cover property ($rose(linkOut.rstTrigReq));
	cover property ($rose(linkOut.txHalt));
endmodule
bind dlcs_link_control_status dlcs_link_control_status_sva i_dlcs_link_control_status_sva(
	.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
	.linkIn(linkIn), .linkOut(linkOut));

// ===== dlcs_panel_model.sv
`timescale 1ns/10ps
module dlcs_panel_model
	import dlcs_pkg::*;
(
	input wire logic slow,
	input wire dlcs_link_in_t stim,
	input wire dlcs_link_out_t linkOut,
	output logic linkClk,
	output dlcs_link_in_t linkIn
);
	logic ph;
	initial begin
		linkClk = 1'b0;
		linkIn = '0;
		ph = 1'b0;
		#37;
		forever #80 linkClk = ~linkClk;
	end
	// pins move on the falling edge so they sit still at the sampled edge
	always @(negedge linkClk) begin
		dlcs_link_in_t nxt;
		nxt = stim;
		nxt.btaReturned = linkOut.btaReq && (!slow || ph);
		nxt.rstTrigDone = linkOut.rstTrigReq && (!slow || ph);
		ph <= ~ph;
		linkIn <= nxt;
	end
endmodule

// ===== dlcs_link_control_status_tb.sv
`timescale 1ns/10ps
module dlcs_link_control_status_tb;
	import dlcs_pkg::*;
	logic ref_clk, resetn, regWrStrobe, regRdStrobe, linkClk, slow, rdPend;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData, w;
	dlcs_link_in_t linkIn, stim, s;
	dlcs_link_out_t linkOut;
	logic [15:0] expQ[$];
	int failures, checks, n;
	dlcs_link_control_status i_dlcs_link_control_status(.ref_clk(ref_clk), .resetn(resetn),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe), .regRdData(regRdData), .linkClk(linkClk),
		.linkIn(linkIn), .linkOut(linkOut));
	dlcs_panel_model i_dlcs_panel_model(.slow(slow), .stim(stim), .linkOut(linkOut),
		.linkClk(linkClk), .linkIn(linkIn));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWrStrobe <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regRdStrobe <= 1'b1;
		regAddr <= a;
		expQ.push_back(e);
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
	endtask
	// pulses last exactly one link cycle, levels persist
	task automatic put;
		@(posedge ref_clk);
		stim <= s;
		@(negedge linkClk);
		@(posedge ref_clk);
		s.respValid = 1'b0;
		s.txRequest = 1'b0;
		s.writePktDone = 1'b0;
		stim <= s;
		// levels must be captured by the design before the caller goes on
		@(posedge linkClk);
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic seen(input int b, input logic v);
		for (n = 0; n < 200 && linkOut[b] !== v; n++) @(negedge ref_clk);
		chk("linkOut bit", {15'h0000, v}, {15'h0000, linkOut[b]});
	endtask
	always @(posedge ref_clk) rdPend <= regRdStrobe;
	always @(negedge ref_clk) begin
		if (rdPend === 1'b1) begin
			chk("regRdData", expQ.pop_front(), regRdData);
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		wrap_up;
	end
	initial begin
		{resetn, regWrStrobe, regRdStrobe, rdPend, slow} = 5'h00;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		s = '0;
		stim = '0;
		void'($urandom(32'h0437));
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(8'hc2, 16'h0000);
		rd(8'hc3, 16'h0000);
		rd(8'hc5, 16'h0000);
		wr(8'hc4, 16'hffc3);
		rd(8'hc4, 16'h0003);
		wr(8'hc4, 16'h0001);
		s.linkIdle = 1'b1;
		s.writePktDone = 1'b1;
		put;
		seen(3, 1'b1);
		repeat (64) @(posedge ref_clk);
		seen(3, 1'b0);
		wr(8'hc4, 16'h000a);
		slow <= 1'b1;
		seen(3, 1'b1);
		seen(3, 1'b0);
		seen(3, 1'b1);
		seen(1, 1'b1);
		rd(8'hc4, 16'h0002);
		s.txRequest = 1'b1;
		s.hsSelect = 1'b1;
		put;
		seen(1, 1'b0);
		seen(0, 1'b1);
		wr(8'hc4, 16'h0000);
		s.videoMode = 1'b1;
		s.vertActive = 1'b1;
		put;
		wr(8'hc4, 16'h0008);
		repeat (64) @(posedge ref_clk);
		seen(3, 1'b0);
		rd(8'hc4, 16'h0008);
		s.vertActive = 1'b0;
		put;
		seen(3, 1'b1);
		seen(3, 1'b0);
		s.vertActive = 1'b1;
		put;
		wr(8'hc4, 16'h0010);
		repeat (64) @(posedge ref_clk);
		seen(4, 1'b0);
		rd(8'hc4, 16'h0010);
		s.vertActive = 1'b0;
		put;
		seen(4, 1'b1);
		seen(4, 1'b0);
		rd(8'hc4, 16'h0000);
		w = 16'($urandom);
		s.respValid = 1'b1;
		s.respIsAckErr = 1'b1;
		s.respWord = w;
		put;
		repeat (48) @(posedge ref_clk);
		wr(8'hc3, ~w);
		wr(8'hc2, ~w);
		rd(8'hc3, w);
		rd(8'hc2, 16'h0000);
		s.respValid = 1'b1;
		s.respIsAckErr = 1'b0;
		s.respIsRead = 1'b1;
		s.respWord = ~w;
		put;
		repeat (48) @(posedge ref_clk);
		rd(8'hc2, ~w);
		rd(8'hc3, 16'h0000);
		wr(8'hc4, 16'h0004);
		seen(2, 1'b1);
		s.phyContention = 1'b1;
		put;
		seen(5, 1'b1);
		s.phyContention = 1'b0;
		put;
		seen(2, 1'b0);
		wr(8'hc4, 16'h0020);
		seen(5, 1'b0);
		s.phyContention = 1'b1;
		put;
		repeat (48) @(posedge ref_clk);
		seen(5, 1'b0);
		wrap_up;
	end
endmodule
